// ---- design/nco_out_shaper.v ----
/*
 * Output shaping: toggle in fixed duty mode, stretched pulse in pulse
 * frequency mode. Produces the raw, non-inverted output.
 * Assumes ticks come from the clock selection and carries from the accumulator logic.
 */
`timescale 1ns/10ps
`default_nettype none

module nco_out_shaper (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// control
	input wire i_module_on,
	input wire i_pulse_mode,
	input wire [2:0] i_pulse_width_select,
	// events
	input wire i_tick,
	input wire i_carry,
	// raw output level
	output reg o_raw
);

	reg [6:0] width_q;

	// width count holds the oscillator periods still to stay active
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_raw <= 1'b0;
			width_q <= 7'h00;
		end else if (!i_module_on) begin
			o_raw <= 1'b0;
			width_q <= 7'h00;
		end else if (i_tick) begin
			if (!i_pulse_mode) begin
				if (i_carry) begin
					o_raw <= ~o_raw;
				end
			end else if (i_carry) begin
				o_raw <= 1'b1;
				width_q <= (7'h01 << i_pulse_width_select) - 7'h01;
			end else if (o_raw && width_q == 7'h00) begin
				o_raw <= 1'b0;
			end else if (o_raw) begin
				width_q <= width_q - 7'h01;
			end
		end
	end

endmodule // nco_out_shaper
`default_nettype wire

// ---- design/nco_regs.vh ----
/*
 * Register map, field positions, reset values and widths of the
 * numerically controlled oscillator.
 * Assumes an 8-bit register port with a 4-bit address.
 */
`ifndef NCO_REGS_VH
`define NCO_REGS_VH

// datapath widths
`define NCO_ACC_W 20
`define NCO_STEP_W 16
`define NCO_ADDR_W 4
`define NCO_DATA_W 8

// register addresses
`define NCO_ADDR_CONTROL 4'h0
`define NCO_ADDR_CLOCK_CONTROL 4'h1
`define NCO_ADDR_ACC_LOW 4'h2
`define NCO_ADDR_ACC_HIGH 4'h3
`define NCO_ADDR_ACC_UPPER 4'h4
`define NCO_ADDR_STEP_LOW 4'h5
`define NCO_ADDR_STEP_HIGH 4'h6
`define NCO_ADDR_IRQ 4'h7

// osc_control fields
`define NCO_CTL_MODULE_ON 7
`define NCO_CTL_PIN_DRIVE_ON 6
`define NCO_CTL_OUTPUT_LEVEL 5
`define NCO_CTL_OUTPUT_INVERT 4
`define NCO_CTL_PULSE_MODE 0

// osc_clock_control fields
`define NCO_CLK_PWS_HI 7
`define NCO_CLK_PWS_LO 5
`define NCO_CLK_CKS_HI 1
`define NCO_CLK_CKS_LO 0

// clock source codes
`define NCO_CKS_FAST_OSC 2'h0
`define NCO_CKS_SYS_CLK 2'h1
`define NCO_CKS_LOGIC_CELL 2'h2
`define NCO_CKS_EXT_PIN 2'h3

// irq register fields
`define NCO_IRQ_FLAG 0
`define NCO_IRQ_ENABLE 1

// reset values
`define NCO_RST_BYTE 8'h00
`define NCO_RST_STEP_LOW 8'h01
`define NCO_RST_STEP 16'h0001

// oscillator clock edges from a low-byte write to the buffer load
`define NCO_STEP_LOAD_EDGES 2'h2

`endif

// ---- design/nco_tick_sel.v ----
/*
 * Oscillator clock selection: turns the chosen source into a one-cycle
 * tick per rising edge of that source.
 * Assumes all sources are synchronous to the core clock and slower than it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "nco_regs.vh"

module nco_tick_sel (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// source selection
	input wire [1:0] i_sel,
	// candidate sources
	input wire i_fast_osc,
	input wire i_logic_cell,
	input wire i_ext_pin,
	// one tick per source rising edge
	output reg o_tick
);

	reg [2:0] prev_q;
	reg level;
	reg prev;

	// remember last level of each source for edge detection
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			prev_q <= 3'h0;
		end else begin
			prev_q <= {i_ext_pin, i_logic_cell, i_fast_osc};
		end
	end

	// the system clock source ticks every cycle, others on a rising edge
	always @* begin
		level = 1'b0;
		prev = 1'b0;
		o_tick = 1'b0;
		case (i_sel)
			`NCO_CKS_FAST_OSC: begin
				level = i_fast_osc;
				prev = prev_q[0];
				o_tick = level & ~prev;
			end
			`NCO_CKS_SYS_CLK: begin
				o_tick = 1'b1;
			end
			`NCO_CKS_LOGIC_CELL: begin
				level = i_logic_cell;
				prev = prev_q[1];
				o_tick = level & ~prev;
			end
			default: begin
				level = i_ext_pin;
				prev = prev_q[2];
				o_tick = level & ~prev;
			end
		endcase
	end

endmodule // nco_tick_sel
`default_nettype wire

// ---- design/nco_top.v ----
/*
 * Numerically controlled oscillator: 20-bit phase accumulator with a
 * double-buffered 16-bit step value, fixed duty or pulse output,
 * polarity control, overflow flag and register port.
 * Assumes a single core clock; oscillator sources arrive as levels
 * synchronous to it, and interrupt enables outside the block arrive as
 * plain inputs.
 */
// Summary of operation
// - 20-bit accumulator adds active step on each selected oscillator clock edge.
// - accumulator carry out is the raw overflow event.
// - adder advances only on the selected oscillator clock, not the register port.
// - accumulator readable and writable as three bytes, upper nibble reads zero.
// - two 8-bit registers form the 16-bit step value.
// - while running, low-byte write loads buffer on second oscillator edge after.
// - while stopped, any step write loads the buffer at once.
// - accumulator adds the hidden buffer, never the registers directly.
// - fixed duty mode toggles output on every overflow.
// - control bit 0 selects pulse mode when set, fixed duty when clear.
// - pulse mode goes active at overflow edge, holds, then returns inactive.
// - pulse width field selects 2 to the power value oscillator periods.
// - clock select: fast osc, system clock, logic cell one, external pin.
// - polarity is final stage; bit 4 set inverts output.
// - polarity change with interrupts enabled raises an interrupt.
// - control bit 5 reads output level; output routed to peripherals.
// - bit 6 drives pin, bit 7 enables module.
// - overflow sets flag; request needs all four enables.
// - flag stays set until software clears it.
// - reset clears all registers to zero, except the step low byte and step buffer, which reset to a step of 1.
// - keeps running while source active; fast osc kept on when used.
`timescale 1ns/10ps
`default_nettype none
`include "nco_regs.vh"

module nco_top (
	// clock and reset
	input wire I_CORE_CLK,
	input wire I_RSTN,
	// register port
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [7:0] O_RDATA,
	// oscillator clock sources
	input wire I_INTERNAL_FAST_OSC,
	input wire I_LOGIC_CELL_ONE_OUTPUT,
	input wire I_EXT_CLK_PIN,
	// interrupt enables held outside the block
	input wire I_PERIPHERAL_IRQ_ENABLE,
	input wire I_GLOBAL_IRQ_ENABLE,
	// interrupt and events
	output wire O_IRQ,
	output reg O_ACCUMULATOR_CARRY,
	// oscillator output
	output wire O_NCO_OUT,
	output wire O_NCO_PIN,
	output wire O_NCO_PIN_OE_N,
	// sleep support
	output wire O_FAST_OSC_KEEP_ON
);

	// register write decode, used for every register
	function wr_hit;
		input [3:0] addr;
		input wr;
		input [3:0] target;
		begin
			wr_hit = wr & (addr == target);
		end
	endfunction

	// software visible registers
	reg module_on_q;
	reg pin_drive_on_q;
	reg output_invert_q;
	reg pulse_mode_select_q;
	reg [2:0] pulse_width_select_q;
	reg [1:0] clock_source_select_q;
	reg [19:0] phase_accumulator_q;
	reg [7:0] step_low_q;
	reg [7:0] step_high_q;
	reg overflow_flag_q;
	reg overflow_irq_enable_q;

	// hidden step buffer and its load sequencer
	reg [15:0] step_buf_q;
	reg [1:0] load_cnt_q;

	// write strobes per register
	wire wr_ctl;
	wire wr_clk;
	wire wr_acc_l;
	wire wr_acc_h;
	wire wr_acc_u;
	wire wr_step_l;
	wire wr_step_h;
	wire wr_irq;

	// datapath
	wire tick;
	wire [20:0] sum;
	wire carry;
	wire acc_wr;
	wire raw_out;
	wire pol_change;

	assign wr_ctl = wr_hit(I_ADDR, I_WR, `NCO_ADDR_CONTROL);
	assign wr_clk = wr_hit(I_ADDR, I_WR, `NCO_ADDR_CLOCK_CONTROL);
	assign wr_acc_l = wr_hit(I_ADDR, I_WR, `NCO_ADDR_ACC_LOW);
	assign wr_acc_h = wr_hit(I_ADDR, I_WR, `NCO_ADDR_ACC_HIGH);
	assign wr_acc_u = wr_hit(I_ADDR, I_WR, `NCO_ADDR_ACC_UPPER);
	assign wr_step_l = wr_hit(I_ADDR, I_WR, `NCO_ADDR_STEP_LOW);
	assign wr_step_h = wr_hit(I_ADDR, I_WR, `NCO_ADDR_STEP_HIGH);
	assign wr_irq = wr_hit(I_ADDR, I_WR, `NCO_ADDR_IRQ);

	// oscillator clock edges become one-cycle ticks of the core clock
	nco_tick_sel u_tick (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_sel(clock_source_select_q),
		.i_fast_osc(I_INTERNAL_FAST_OSC),
		.i_logic_cell(I_LOGIC_CELL_ONE_OUTPUT),
		.i_ext_pin(I_EXT_CLK_PIN),
		.o_tick(tick)
	);

	// adder works on the hidden buffer, zero extended to accumulator width
	assign sum = {1'b0, phase_accumulator_q} + {5'h00, step_buf_q};
	// a software byte write replaces the addition, so no overflow in that cycle
	assign acc_wr = wr_acc_l | wr_acc_h | wr_acc_u;
	assign carry = module_on_q & tick & ~acc_wr & sum[20];

	// control register fields
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			module_on_q <= 1'b0;
			pin_drive_on_q <= 1'b0;
			output_invert_q <= 1'b0;
			pulse_mode_select_q <= 1'b0;
		end else if (wr_ctl) begin
			module_on_q <= I_WDATA[`NCO_CTL_MODULE_ON];
			pin_drive_on_q <= I_WDATA[`NCO_CTL_PIN_DRIVE_ON];
			output_invert_q <= I_WDATA[`NCO_CTL_OUTPUT_INVERT];
			pulse_mode_select_q <= I_WDATA[`NCO_CTL_PULSE_MODE];
		end
	end

	// clock control fields
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pulse_width_select_q <= 3'h0;
			clock_source_select_q <= 2'h0;
		end else if (wr_clk) begin
			pulse_width_select_q <= I_WDATA[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
			clock_source_select_q <= I_WDATA[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO];
		end
	end

	// accumulator: a software byte write wins over a same-cycle addition
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			phase_accumulator_q <= 20'h00000;
		end else if (acc_wr) begin
			if (wr_acc_l) begin
				phase_accumulator_q[7:0] <= I_WDATA;
			end
			if (wr_acc_h) begin
				phase_accumulator_q[15:8] <= I_WDATA;
			end
			if (wr_acc_u) begin
				phase_accumulator_q[19:16] <= I_WDATA[3:0];
			end
		end else if (module_on_q && tick) begin
			phase_accumulator_q <= sum[19:0];
		end
	end

	// step value registers
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			step_low_q <= `NCO_RST_STEP_LOW;
			step_high_q <= `NCO_RST_BYTE;
		end else begin
			if (wr_step_l) begin
				step_low_q <= I_WDATA;
			end
			if (wr_step_h) begin
				step_high_q <= I_WDATA;
			end
		end
	end

	// buffer load: at once while stopped, two oscillator edges later while running
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			step_buf_q <= `NCO_RST_STEP;
			load_cnt_q <= 2'h0;
		end else if (!module_on_q) begin
			load_cnt_q <= 2'h0;
			if (wr_step_l) begin
				step_buf_q <= {step_high_q, I_WDATA};
			end else if (wr_step_h) begin
				step_buf_q <= {I_WDATA, step_low_q};
			end
		end else if (wr_step_l) begin
			load_cnt_q <= `NCO_STEP_LOAD_EDGES;
		end else if (load_cnt_q != 2'h0 && tick) begin
			load_cnt_q <= load_cnt_q - 2'h1;
			if (load_cnt_q == 2'h1) begin
				step_buf_q <= {step_high_q, step_low_q};
			end
		end
	end

	// output waveform before polarity
	nco_out_shaper u_shape (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_module_on(module_on_q),
		.i_pulse_mode(pulse_mode_select_q),
		.i_pulse_width_select(pulse_width_select_q),
		.i_tick(tick),
		.i_carry(carry),
		.o_raw(raw_out)
	);

	// polarity is the final stage; the level goes to pin and peripherals
	assign O_NCO_OUT = raw_out ^ output_invert_q;
	assign O_NCO_PIN = O_NCO_OUT;
	assign O_NCO_PIN_OE_N = ~(module_on_q & pin_drive_on_q);

	// polarity flip while interrupts are enabled makes an output transition
	assign pol_change = wr_ctl & module_on_q & overflow_irq_enable_q
		& (I_WDATA[`NCO_CTL_OUTPUT_INVERT] != output_invert_q);

	// overflow flag: a hardware set beats a same-cycle software clear
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			overflow_flag_q <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
		end else begin
			if (carry | pol_change) begin
				overflow_flag_q <= 1'b1;
			end else if (wr_irq) begin
				overflow_flag_q <= I_WDATA[`NCO_IRQ_FLAG];
			end
			if (wr_irq) begin
				overflow_irq_enable_q <= I_WDATA[`NCO_IRQ_ENABLE];
			end
		end
	end

	// request needs every enable in the chain
	assign O_IRQ = overflow_flag_q & module_on_q & overflow_irq_enable_q
		& I_PERIPHERAL_IRQ_ENABLE & I_GLOBAL_IRQ_ENABLE;

	// carry pulse for observers, one core cycle per overflow
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_ACCUMULATOR_CARRY <= 1'b0;
		end else begin
			O_ACCUMULATOR_CARRY <= carry;
		end
	end

	// the fast oscillator must stay alive in sleep when it feeds us
	assign O_FAST_OSC_KEEP_ON = module_on_q
		& (clock_source_select_q == `NCO_CKS_FAST_OSC);

	// read data stands only in the cycle after the read strobe
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA <= 8'h00;
		end else if (!I_RD) begin
			O_RDATA <= 8'h00;
		end else begin
			case (I_ADDR)
				`NCO_ADDR_CONTROL: begin
					O_RDATA <= {module_on_q, pin_drive_on_q, O_NCO_OUT, output_invert_q,
						3'h0, pulse_mode_select_q};
				end
				`NCO_ADDR_CLOCK_CONTROL: begin
					O_RDATA <= {pulse_width_select_q, 3'h0, clock_source_select_q};
				end
				`NCO_ADDR_ACC_LOW: begin
					O_RDATA <= phase_accumulator_q[7:0];
				end
				`NCO_ADDR_ACC_HIGH: begin
					O_RDATA <= phase_accumulator_q[15:8];
				end
				`NCO_ADDR_ACC_UPPER: begin
					O_RDATA <= {4'h0, phase_accumulator_q[19:16]};
				end
				`NCO_ADDR_STEP_LOW: begin
					O_RDATA <= step_low_q;
				end
				`NCO_ADDR_STEP_HIGH: begin
					O_RDATA <= step_high_q;
				end
				`NCO_ADDR_IRQ: begin
					O_RDATA <= {6'h00, overflow_irq_enable_q, overflow_flag_q};
				end
				default: begin
					O_RDATA <= 8'h00;
				end
			endcase
		end
	end

endmodule // nco_top
`default_nettype wire

// ---- tb/nco_monitor.sv ----
/* port checker for nco_top, bound from the bench top.
   assumes one core clock and an active-low asynchronous reset */
`timescale 1ns/10ps
`default_nettype none
module nco_monitor (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	// register port
	input wire logic [3:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [7:0] O_RDATA,
	// enables and outputs
	input wire logic I_PERIPHERAL_IRQ_ENABLE,
	input wire logic I_GLOBAL_IRQ_ENABLE,
	input wire logic O_IRQ,
	input wire logic O_ACCUMULATOR_CARRY,
	input wire logic O_NCO_OUT,
	input wire logic O_NCO_PIN,
	input wire logic O_NCO_PIN_OE_N,
	input wire logic O_FAST_OSC_KEEP_ON
);
	logic [7:0] ctl_q;
	logic [1:0] cks_q;
	logic ie_q;
	// shadow of the control bits software has written
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctl_q <= 8'h00;
			cks_q <= 2'h0;
			ie_q <= 1'b0;
		end else if (I_WR) begin
			if (I_ADDR == 4'h0) ctl_q <= I_WDATA;
			if (I_ADDR == 4'h1) cks_q <= I_WDATA[1:0];
			if (I_ADDR == 4'h7) ie_q <= I_WDATA[1];
		end
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RSTN);
	property p_pin;
		O_NCO_PIN == O_NCO_OUT;
	endproperty
	a_pin: assert property (p_pin) else $error("pin differs from output");
	property p_rd_idle;
		!$past(I_RD) |-> O_RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_ctl_read;
		$past(I_RD) && $past(I_ADDR) == 4'h0 |-> O_RDATA[3:1] == 3'h0 && O_RDATA[5] == $past(O_NCO_OUT);
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
	property p_carry_once;
		O_ACCUMULATOR_CARRY |=> !O_ACCUMULATOR_CARRY;
	endproperty
	a_carry_once: assert property (p_carry_once) else $error("carry longer than one cycle");
	property p_toggle;
		O_ACCUMULATOR_CARRY && !ctl_q[0] && $stable(ctl_q) |-> O_NCO_OUT != $past(O_NCO_OUT);
	endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle on overflow");
	property p_off_quiet;
		!ctl_q[7] && !$past(ctl_q[7]) && !$past(ctl_q[7], 2) |-> !O_ACCUMULATOR_CARRY;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("carry while disabled");
	property p_off_level;
		!ctl_q[7] && !$past(ctl_q[7]) |-> O_NCO_OUT == ctl_q[4];
	endproperty
	a_off_level: assert property (p_off_level) else $error("idle level wrong");
	property p_pin_drive;
		O_NCO_PIN_OE_N == !(ctl_q[7] && ctl_q[6]);
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin enable wrong");
	property p_keep_on;
		O_FAST_OSC_KEEP_ON == (ctl_q[7] && cks_q == 2'h0);
	endproperty
	a_keep_on: assert property (p_keep_on) else $error("fast osc hold wrong");
	property p_irq_gate;
		O_IRQ |-> ctl_q[7] && ie_q && I_PERIPHERAL_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enables");
endmodule // nco_monitor
`default_nettype wire

// ---- tb/nco_src_model.sv ----
/* far-side model: free-running oscillator sources at three rates.
   assumes the core clock and reset of the bench */
`timescale 1ns/10ps
`default_nettype none
module nco_src_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// source levels
	output logic o_fast_osc,
	output logic o_logic_cell,
	output logic o_ext_pin
);
	logic [3:0] cnt_q;
	// divider chain, sources run free as real oscillators do
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	// periods of 4, 8 and 16 core cycles
	assign o_fast_osc = cnt_q[1];
	assign o_logic_cell = cnt_q[2];
	assign o_ext_pin = cnt_q[3];
endmodule // nco_src_model
`default_nettype wire

// ---- tb/nco_top_tb_top.sv ----
/* bench top: register access, carry timing, pulse widths, polarity.
   assumes nco_top, nco_src_model and nco_monitor are compiled first */
`timescale 1ns/10ps
`default_nettype none
module nco_top_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pie = 1'b0;
	logic global_irq_enable = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	wire [7:0] rdata;
	wire irq, carry, out, pin, oe_n, keep, fosc, lco, ext;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	int per[4] = '{4, 1, 8, 16};
	initial forever #20 clk = ~clk;
	nco_top u_nco_top (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_INTERNAL_FAST_OSC(fosc),
		.I_LOGIC_CELL_ONE_OUTPUT(lco), .I_EXT_CLK_PIN(ext), .I_PERIPHERAL_IRQ_ENABLE(pie),
		.I_GLOBAL_IRQ_ENABLE(global_irq_enable), .O_IRQ(irq), .O_ACCUMULATOR_CARRY(carry), .O_NCO_OUT(out),
		.O_NCO_PIN(pin), .O_NCO_PIN_OE_N(oe_n), .O_FAST_OSC_KEEP_ON(keep));
	nco_src_model u_nco_src_model (.i_clk(clk), .i_rstn(rstn), .o_fast_osc(fosc),
		.o_logic_cell(lco), .o_ext_pin(ext));
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares = miscompares + 1;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bus cycles, each followed by one idle cycle
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(16'(rdata), 16'(e));
	endtask
	task automatic wait_carry(output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (carry !== 1'b1 && k < 3000);
	endtask
	task automatic t_reset();
		for (int a = 0; a < 9; a++) reg_rd(a[3:0], (a == 5) ? 8'h01 : 8'h00);
	endtask
	task automatic t_acc();
		reg_wr(4'h2, 8'hFF);
		reg_wr(4'h3, 8'hFF);
		reg_wr(4'h4, 8'hFF);
		reg_wr(4'h6, 8'hA5);
		reg_rd(4'h2, 8'hFF);
		reg_rd(4'h3, 8'hFF);
		reg_rd(4'h4, 8'h0F);
		reg_rd(4'h6, 8'hA5);
	endtask
	// fixed duty on the system clock, flag hold, step reload order
	task automatic t_fdc();
		pie <= 1'b1;
		global_irq_enable <= 1'b1;
		reg_wr(4'h1, 8'h01);
		reg_wr(4'h5, 8'h00);
		reg_wr(4'h6, 8'h80);
		reg_wr(4'h7, 8'h02);
		reg_wr(4'h0, 8'hC0);
		wait_carry(n);
		wait_carry(n);
		chk(16'(n), 16'd32);
		repeat (10) @(posedge clk);
		chk(16'(irq), 16'h0001);
		reg_wr(4'h7, 8'h02);
		chk(16'(irq), 16'h0000);
		reg_wr(4'h6, 8'h20);
		wait_carry(n);
		wait_carry(n);
		chk(16'(n), 16'd32);
		reg_wr(4'h5, 8'h00);
		wait_carry(n);
		wait_carry(n);
		chk(16'(n), 16'd128);
	endtask
	// every pulse width code on a 512-tick overflow period
	task automatic t_pulse();
		int w;
		reg_wr(4'h0, 8'h00);
		reg_wr(4'h6, 8'h08);
		for (int p = 0; p < 8; p++) begin
			reg_wr(4'h1, {p[2:0], 5'h01});
			reg_wr(4'h0, 8'hC1);
			n = 0;
			w = 0;
			while (out !== 1'b1 && n < 1000) begin
				@(posedge clk);
				n++;
			end
			while (out === 1'b1 && w < 300) begin
				@(posedge clk);
				w++;
			end
			chk(16'(w), 16'(1 << p));
			reg_wr(4'h0, 8'h00);
		end
	endtask
	task automatic t_pol();
		reg_wr(4'h0, 8'h10);
		chk(16'(out), 16'h0001);
		for (int a = 2; a < 5; a++) reg_wr(a[3:0], 8'h00);
		reg_wr(4'h0, 8'h80);
		reg_wr(4'h7, 8'h02);
		chk(16'(irq), 16'h0000);
		reg_wr(4'h0, 8'h90);
		chk(16'(irq), 16'h0001);
		reg_rd(4'h0, 8'hB0);
	endtask
	// each clock source, carry spacing scales with its period
	task automatic t_src();
		reg_wr(4'h0, 8'h00);
		reg_wr(4'h6, 8'h80);
		reg_wr(4'h0, 8'h80);
		for (int s = 0; s < 4; s++) begin
			reg_wr(4'h1, s[7:0]);
			wait_carry(n);
			wait_carry(n);
			chk(16'(n), 16'(32 * per[s]));
		end
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_acc();
		t_fdc();
		t_pulse();
		t_pol();
		t_src();
		// reset again while running: every register must return to its reset value
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk(16'(oe_n), 16'h0001);
		t_reset();
		finish_test();
	end
endmodule // nco_top_tb_top
bind nco_top nco_monitor u_nco_monitor (.I_CORE_CLK, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
	.O_RDATA, .I_PERIPHERAL_IRQ_ENABLE, .I_GLOBAL_IRQ_ENABLE, .O_IRQ, .O_ACCUMULATOR_CARRY,
	.O_NCO_OUT, .O_NCO_PIN, .O_NCO_PIN_OE_N, .O_FAST_OSC_KEEP_ON);
`default_nettype wire
